// *** src/sac_top.sv ***
// Register access over Wishbone and the address map were decided locally.
module sac_top
   import sac_pkg::*;
(
   input wire logic clk_i,               // System clock, 100 MHz.
   input wire logic rst_i,               // Synchronous reset, active high.
   input wire logic ser_sel_i,           // Interface select pin, high for serial.
   input wire logic ser_clk_i,           // Serial clock pin from the host.
   input wire logic ser_data_i,          // Serial data pin from the host.
   input wire logic hold_strobe_i,       // Hold strobe pin.
   input wire logic powerup_sel_hi_i,    // High power-up select pin.
   input wire logic powerup_sel_lo_i,    // Low power-up select pin.
   input wire logic weight_sixteen_db_i, // Weight pin, 16 dB.
   input wire logic weight_eight_db_i,   // Weight pin, 8 dB.
   input wire logic weight_four_db_i,    // Weight pin, 4 dB.
   input wire logic weight_two_db_i,     // Weight pin, 2 dB.
   input wire logic weight_one_db_i,     // Weight pin, 1 dB.
   input wire logic weight_half_db_i,    // Weight pin, 0.5 dB.
   output logic [5:0] atten_o,           // Applied attenuation control bits.
   input wire logic wb_cyc_i,            // Wishbone cycle.
   input wire logic wb_stb_i,            // Wishbone strobe.
   input wire logic wb_we_i,             // Wishbone write enable.
   input wire logic [7:0] wb_adr_i,      // Wishbone byte address.
   input wire logic [3:0] wb_sel_i,      // Wishbone byte selects.
   input wire logic [31:0] wb_dat_i,     // Wishbone write data.
   output logic [31:0] wb_dat_o,         // Wishbone read data.
   output logic wb_ack_o                 // Wishbone acknowledge.
);

   ////////////////////////////////////////////////////////////////////////////////

   sac_pins_if pins(); // Synchronised pins and shift word.

   logic [11:0] raw_pins; // Raw pin word handed to the synchroniser.
   logic [5:0] weights_raw; // Raw weight pins gathered into one word.
   sac_top_state_t st_r; // Registered state.
   sac_top_state_t st_nxt; // Next state.
   logic bus_req; // A new bus request is waiting for its answer.
   logic pup_wr; // Software asks for a fresh power-up evaluation.
   logic [31:0] status_word; // Status register contents.

   // The six weights take their binary positions, 16 dB at the top.
   assign weights_raw = sac_pack_weights(weight_sixteen_db_i, weight_eight_db_i,
                                         weight_four_db_i, weight_two_db_i,
                                         weight_one_db_i, weight_half_db_i);

   // All pins come from outside the clock domain and are synchronised together.
   assign raw_pins = {ser_clk_i, ser_data_i, hold_strobe_i, ser_sel_i,
                      powerup_sel_hi_i, powerup_sel_lo_i, weights_raw};

   // Two-stage synchroniser and serial clock edge finder.
   sac_pin_sync u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(raw_pins),
      .pins(pins)
   );

   // Six-stage serial shift register.
   sac_shift_reg u_shift (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////////////

   // Returns the read value of one register, zero for unmapped addresses.
   function automatic logic [31:0] sac_read_mux(input logic [7:0] adr,
                                                input logic [5:0] atten,
                                                input logic [5:0] word,
                                                input logic [31:0] stat);
      case (adr)
         `SAC_ADR_ATTEN: sac_read_mux = {26'h0000000, atten};
         `SAC_ADR_SHIFT: sac_read_mux = {26'h0000000, word};
         `SAC_ADR_STATUS: sac_read_mux = stat;
         default: sac_read_mux = 32'h0000_0000;
      endcase
   endfunction

   // Status shows the selected interface, the strobe, whether the phase is PH_RUN and the source.
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SAC_STAT_SERIAL_BIT] = pins.ser_sel;
      status_word[`SAC_STAT_STROBE_BIT] = pins.strobe;
      status_word[`SAC_STAT_RUN_BIT] = (st_r.phase == PH_RUN);
      status_word[`SAC_STAT_SRC_LSB +: 2] = st_r.src;
   end

   // A request is new while cycle and strobe stand and no answer is out yet.
   assign bus_req = wb_cyc_i & wb_stb_i & ~st_r.ack;

   // The control register takes a one in its low bit through byte lane zero.
   assign pup_wr = bus_req & wb_we_i & (wb_adr_i == `SAC_ADR_CTRL) & wb_sel_i[0] &
                   wb_dat_i[`SAC_CTRL_PUP_BIT];

   ////////////////////////////////////////////////////////////////////////////////

   // Next-state logic: power-up evaluation, latch behaviour and bus answers.
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = bus_req;
      st_nxt.rdata = `SAC_RDATA_RST;
      // Read data is prepared in the same cycle as the acknowledge.
      if (bus_req && !wb_we_i) begin
         st_nxt.rdata = sac_read_mux(wb_adr_i, st_r.atten, pins.shift_word, status_word);
      end
      case (st_r.phase)
         PH_SETTLE: begin
            // Wait until the synchronisers hold real pin levels.
            if (st_r.settle == `SAC_SETTLE_CYCLES) begin
               st_nxt.phase = PH_EVAL;
            end else begin
               st_nxt.settle = st_r.settle + 2'h1;
            end
         end
         PH_EVAL: begin
            // One cycle that sets the power-up state from the pins.
            st_nxt.phase = PH_RUN;
            if (pins.ser_sel) begin
               st_nxt.atten = pins.weights;
               st_nxt.src = `SAC_SRC_SERIAL;
            end else if (!pins.strobe) begin
               st_nxt.atten = sac_pup_state(pins.pup_hi, pins.pup_lo);
               st_nxt.src = `SAC_SRC_PUP_PINS;
            end else begin
               st_nxt.atten = pins.weights;
               st_nxt.src = `SAC_SRC_PARALLEL;
            end
         end
         PH_RUN: begin
            // The strobe opens the latch; a low strobe holds the last word.
            if (pins.strobe) begin
               if (pins.ser_sel) begin
                  st_nxt.atten = pins.shift_word;
               end else begin
                  st_nxt.atten = pins.weights;
               end
            end else begin
               // Held here, which also keeps any power-up state in place.
               st_nxt.atten = st_r.atten;
            end
         end
         default: begin
            st_nxt.phase = PH_SETTLE;
         end
      endcase
      // Software can ask for the power-up choice to be taken again.
      if (pup_wr) begin
         st_nxt.phase = PH_EVAL;
      end
   end

   // Registers the whole core state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.phase <= PH_SETTLE;
         st_r.settle <= 2'h0;
         st_r.atten <= `SAC_ATTEN_RST;
         st_r.src <= `SAC_SRC_NONE;
         st_r.ack <= 1'b0;
         st_r.rdata <= `SAC_RDATA_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs come straight from flip-flops.
   assign atten_o = st_r.atten;
   assign wb_dat_o = st_r.rdata;
   assign wb_ack_o = st_r.ack;

   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Steps of interest for the checks below.
   sequence s_run_serial_open;
      st_r.phase == PH_RUN && !pup_wr && pins.ser_sel && pins.strobe;
   endsequence

   sequence s_run_parallel_open;
      st_r.phase == PH_RUN && !pup_wr && !pins.ser_sel && pins.strobe;
   endsequence

   sequence s_run_closed;
      st_r.phase == PH_RUN && !pup_wr && !pins.strobe;
   endsequence

   sequence s_pup_pins;
      st_r.phase == PH_EVAL && !pup_wr && !pins.ser_sel && !pins.strobe;
   endsequence

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   // Serial mode with the strobe high passes the shift word through.
   AST_SER_TRANSPARENT: assert property (
      s_run_serial_open |=> atten_o == $past(pins.shift_word))
      else $error("Open latch did not pass the shift word.");

   // Parallel mode with the strobe high follows the weights.
   AST_PAR_DIRECT: assert property (
      s_run_parallel_open |=> atten_o == $past(pins.weights))
      else $error("Direct parallel mode did not follow the weights.");

   // A low strobe holds the word in either mode.
   AST_LATCH_HOLD: assert property (
      s_run_closed |=> $stable(atten_o))
      else $error("Closed latch changed the applied word.");

   // The select pin decides which source an open latch passes.
   AST_MODE_SELECT: assert property (
      (st_r.phase == PH_RUN && !pup_wr && pins.strobe) |=>
         atten_o == ($past(pins.ser_sel) ? $past(pins.shift_word) : $past(pins.weights)))
      else $error("Wrong source applied for the selected interface.");

   // Serial power-up takes the weight pins.
   AST_PUP_SERIAL: assert property (
      (st_r.phase == PH_EVAL && !pup_wr && pins.ser_sel) |=>
         atten_o == $past(pins.weights) ##0 st_r.phase == PH_RUN)
      else $error("Serial power-up did not load the weight pins.");

   // Parallel power-up with the strobe low takes the select pin table.
   AST_PUP_PINS: assert property (
      s_pup_pins |=> atten_o == sac_pup_state($past(pins.pup_hi), $past(pins.pup_lo)))
      else $error("Power-up select pins not applied.");

   // Parallel power-up with the strobe high ignores the select pins.
   AST_PUP_NORMAL: assert property (
      (st_r.phase == PH_EVAL && !pup_wr && !pins.ser_sel && pins.strobe) |=>
         atten_o == $past(pins.weights))
      else $error("Parallel power-up with strobe high did not use the weights.");

   // The power-up select state lasts while the strobe stays low.
   // It first shows on the output one cycle after the evaluation cycle.
   AST_PUP_HELD: assert property (
      s_pup_pins ##1 s_run_closed [*4] |=> atten_o == $past(atten_o, 4))
      else $error("Power-up select state lost before a strobe pulse.");

   // Each request is answered in the next cycle and the answer lasts one cycle.
   AST_WB_ACK: assert property (
      s_bus_req |=> wb_ack_o ##1 !wb_ack_o)
      else $error("Bus answer not one cycle after the request.");

endmodule

// *** include/sac_params.svh ***
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////

// Register byte offsets on the Wishbone bus.
`define SAC_ADR_CTRL 8'h00
`define SAC_ADR_ATTEN 8'h04
`define SAC_ADR_SHIFT 8'h08
`define SAC_ADR_STATUS 8'h0C

// Control register field: writing one re-runs the power-up evaluation.
`define SAC_CTRL_PUP_BIT 0

// Status register field positions.
`define SAC_STAT_SERIAL_BIT 0
`define SAC_STAT_STROBE_BIT 1
`define SAC_STAT_RUN_BIT 2
`define SAC_STAT_SRC_LSB 4

////////////////////////////////////////////////////////////////////////////////

// Positions of the pins inside the synchroniser word.
`define SAC_PIN_SCLK 11
`define SAC_PIN_SDATA 10
`define SAC_PIN_STROBE 9
`define SAC_PIN_SEL 8
`define SAC_PIN_PUP_HI 7
`define SAC_PIN_PUP_LO 6
`define SAC_PIN_W_MSB 5

// Reset values.
`define SAC_SYNC_RST 12'h000
`define SAC_ATTEN_RST 6'h00
`define SAC_SHIFT_RST 6'h00
`define SAC_RDATA_RST 32'h0000_0000

// Power-up select states in half-dB steps: 0, 8, 16 and 31 dB.
`define SAC_PUP_REF 6'h00
`define SAC_PUP_8DB 6'h10
`define SAC_PUP_16DB 6'h20
`define SAC_PUP_31DB 6'h3E

// Cycles allowed for the synchronisers to fill before power-up evaluation.
`define SAC_SETTLE_CYCLES 2'h3

// Power-up source codes shown in the status register.
`define SAC_SRC_NONE 2'h0
`define SAC_SRC_SERIAL 2'h1
`define SAC_SRC_PUP_PINS 2'h2
`define SAC_SRC_PARALLEL 2'h3

`endif

// *** include/sac_pkg.sv ***
`include "sac_params.svh"

package sac_pkg;

   // Phases of the control core.
   typedef enum logic [1:0] {
      PH_SETTLE,
      PH_EVAL,
      PH_RUN
   } sac_phase_t;

   // State of the pin synchroniser.
   typedef struct packed {
      logic [11:0] s1; // First stage, read only by the second.
      logic [11:0] s2; // Second stage, the usable level.
      logic sclk_d;    // Delayed serial clock for edge finding.
   } sac_sync_state_t;

   // State of the serial shift register.
   typedef struct packed {
      logic [5:0] word; // Parallel outputs of the six stages.
   } sac_shift_state_t;

   // State of the control core and its bus slave.
   typedef struct packed {
      sac_phase_t phase;   // Current phase.
      logic [1:0] settle;  // Settle counter.
      logic [5:0] atten;   // Applied attenuation word.
      logic [1:0] src;     // Where the power-up state came from.
      logic ack;           // Wishbone acknowledge.
      logic [31:0] rdata;  // Wishbone read data.
   } sac_top_state_t;

   // Gathers the six weight pins into one word, 16 dB at the top.
   function automatic logic [5:0] sac_pack_weights(input logic w16, input logic w8,
                                                   input logic w4, input logic w2,
                                                   input logic w1, input logic w05);
      sac_pack_weights = {w16, w8, w4, w2, w1, w05};
   endfunction

   // Maps the two power-up select pins to an attenuation word.
   function automatic logic [5:0] sac_pup_state(input logic hi, input logic lo);
      case ({hi, lo})
         2'h0: sac_pup_state = `SAC_PUP_REF;
         2'h1: sac_pup_state = `SAC_PUP_8DB;
         2'h2: sac_pup_state = `SAC_PUP_16DB;
         default: sac_pup_state = `SAC_PUP_31DB;
      endcase
   endfunction

endpackage

// *** include/sac_pins_if.sv ***
// Synchronised pin levels and the shift word shared inside the block.
interface sac_pins_if;
   logic sclk_rise;     // One-cycle pulse on a serial clock rising edge.
   logic sdata;         // Synchronised serial data level.
   logic strobe;        // Synchronised hold strobe level.
   logic ser_sel;       // Synchronised interface select level.
   logic pup_hi;        // Synchronised high power-up select.
   logic pup_lo;        // Synchronised low power-up select.
   logic [5:0] weights; // Synchronised weight inputs, 16 dB at the top.
   logic [5:0] shift_word; // Shift register contents.

   modport sync (output sclk_rise, sdata, strobe, ser_sel, pup_hi, pup_lo, weights);
   modport shifter (input sclk_rise, sdata, output shift_word);
   modport core (input sclk_rise, sdata, strobe, ser_sel, pup_hi, pup_lo, weights,
                 shift_word);
endinterface

// *** src/sac_pin_sync.sv ***
module sac_pin_sync
   import sac_pkg::*;
(
   input wire logic clk_i,        // System clock.
   input wire logic rst_i,        // Synchronous reset, active high.
   input wire logic [11:0] pin_i, // Raw pins from outside the clock domain.
   sac_pins_if.sync pins          // Synchronised levels and edge pulse.
);

   sac_sync_state_t st_r; // Registered state.
   sac_sync_state_t st_nxt; // Next state.

   ////////////////////////////////////////////////////////////////////////////////

   // Two stages per pin; the clock edge is found from the second stage only.
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.sclk_d = st_r.s2[`SAC_PIN_SCLK];
   end

   // Registers the synchroniser state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.s1 <= `SAC_SYNC_RST;
         st_r.s2 <= `SAC_SYNC_RST;
         st_r.sclk_d <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Serial clock rising edge is a one-cycle pulse.
   assign pins.sclk_rise = st_r.s2[`SAC_PIN_SCLK] & ~st_r.sclk_d;
   assign pins.sdata = st_r.s2[`SAC_PIN_SDATA];
   assign pins.strobe = st_r.s2[`SAC_PIN_STROBE];
   assign pins.ser_sel = st_r.s2[`SAC_PIN_SEL];
   assign pins.pup_hi = st_r.s2[`SAC_PIN_PUP_HI];
   assign pins.pup_lo = st_r.s2[`SAC_PIN_PUP_LO];
   assign pins.weights = st_r.s2[`SAC_PIN_W_MSB:0];

endmodule

// *** src/sac_shift_reg.sv ***
module sac_shift_reg
   import sac_pkg::*;
(
   input wire logic clk_i,  // System clock.
   input wire logic rst_i,  // Synchronous reset, active high.
   sac_pins_if.shifter pins // Edge pulse and data in, word out.
);

   sac_shift_state_t st_r; // Registered state.
   sac_shift_state_t st_nxt; // Next state.

   ////////////////////////////////////////////////////////////////////////////////

   // Shifts left on each serial clock rising edge; the strobe plays no part here.
   always_comb begin
      st_nxt = st_r;
      if (pins.sclk_rise) begin
         st_nxt.word = {st_r.word[4:0], pins.sdata};
      end
   end

   // Registers the six stages.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r.word <= `SAC_SHIFT_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // The first bit sent ends up in the top stage after six edges.
   assign pins.shift_word = st_r.word;

   ////////////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // Each edge moves the word up one place and takes the data bit at the bottom.
   AST_SHIFT_EDGE: assert property (
      pins.sclk_rise |=> st_r.word == {$past(st_r.word[4:0]), $past(pins.sdata)})
      else $error("Shift register did not take the bit on the clock edge.");

   // Without an edge the word stays put.
   AST_SHIFT_IDLE: assert property (
      !pins.sclk_rise |=> $stable(st_r.word))
      else $error("Shift register moved without a clock edge.");

endmodule

// *** bench/sac_host_model.sv ***
////////////////////////////////////////////////////////////////////////////////
// Host controller that drives the select, strobe, weight and serial pins.
module sac_host_model (
   input wire logic clk_i,       // System clock, used only for pacing.
   output logic ser_sel_o,       // Interface select, high for serial.
   output logic ser_clk_o,       // Serial clock, low outside frames.
   output logic ser_data_o,      // Serial data.
   output logic hold_strobe_o,   // Hold strobe.
   output logic pup_hi_o,        // High power-up select.
   output logic pup_lo_o,        // Low power-up select.
   output logic [5:0] weights_o  // Weight pins, 16 dB at the top.
);
   timeunit 1ns;
   timeprecision 100ps;

   localparam int HALF = 8; // High time of the 170 ns serial clock in system cycles.

   // All pins start low so that nothing floats at time zero.
   initial begin
      {ser_sel_o, ser_clk_o, ser_data_o, hold_strobe_o, pup_hi_o, pup_lo_o} = 6'h00;
      weights_o = 6'h00;
   end

   // Drives the static pins right after a clock edge.
   task automatic set_pins(input logic sel, input logic stb, input logic hi, input logic lo,
                           input logic [5:0] w);
      @(posedge clk_i);
      ser_sel_o <= sel;
      hold_strobe_o <= stb;
      pup_hi_o <= hi;
      pup_lo_o <= lo;
      weights_o <= w;
   endtask

   // Changes only the weight pins.
   task automatic set_weights(input logic [5:0] w);
      @(posedge clk_i);
      weights_o <= w;
   endtask

   // Raises the strobe and lowers it again to apply a word.
   task automatic strobe_pulse();
      @(posedge clk_i);
      hold_strobe_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
      hold_strobe_o <= 1'b0;
      repeat (HALF) @(posedge clk_i);
   endtask

   // Shifts six bits, most significant first, data settled before each rising edge.
   task automatic send_word(input logic [5:0] w);
      for (int i = 5; i >= 0; i--) begin
         @(posedge clk_i);
         ser_data_o <= w[i];
         repeat (HALF) @(posedge clk_i);
         ser_clk_o <= 1'b1;
         repeat (HALF) @(posedge clk_i);
         ser_clk_o <= 1'b0;
      end
      repeat (HALF) @(posedge clk_i);
      ser_data_o <= ~w[0]; // Hold time over, so the stale bit is not left showing.
   endtask
endmodule

// *** bench/step_attenuator_control_tb.sv ***
`include "sac_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: host pins by the model, registers over Wishbone.
module step_attenuator_control_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic clk_i, rst_i; // Clock and synchronous reset.
   logic wb_cyc, wb_stb, wb_we; // Wishbone request lines.
   logic [7:0] wb_adr; // Wishbone address.
   logic [3:0] wb_sel; // Wishbone byte selects.
   logic [31:0] wb_wdat, wb_dat_o; // Wishbone data.
   logic wb_ack_o; // Wishbone acknowledge.
   logic sel, sclk, sdat, stb, phi, plo; // Host pin levels.
   logic [5:0] wts, atten_o; // Weight pins and applied word.
   logic [31:0] d; // Read data.
   logic [5:0] w, v, prev; // Scenario words.
   int fail_count, checks, cycles; // Counters.
   int seed; // Random seed.

   sac_host_model host_u (.clk_i(clk_i), .ser_sel_o(sel), .ser_clk_o(sclk), .ser_data_o(sdat),
      .hold_strobe_o(stb), .pup_hi_o(phi), .pup_lo_o(plo), .weights_o(wts));

   sac_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ser_sel_i(sel), .ser_clk_i(sclk),
      .ser_data_i(sdat), .hold_strobe_i(stb), .powerup_sel_hi_i(phi), .powerup_sel_lo_i(plo),
      .weight_sixteen_db_i(wts[5]), .weight_eight_db_i(wts[4]), .weight_four_db_i(wts[3]),
      .weight_two_db_i(wts[2]), .weight_one_db_i(wts[1]), .weight_half_db_i(wts[0]),
      .atten_o(atten_o), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o));

   // The 100 MHz system clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Power-up word chosen by the select pins, in half-dB steps.
   function automatic logic [5:0] pup_exp(input int k);
      case (k)
         0: pup_exp = 6'h00;
         1: pup_exp = 6'h10;
         2: pup_exp = 6'h20;
         default: pup_exp = 6'h3E;
      endcase
   endfunction

   // Prints the counts and the verdict, then stops.
   task test_done();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         test_done();
      end
   end

   // Waits up to tmo cycles for the applied word, then compares it.
   task automatic check_atten(input logic [5:0] exp, input int tmo);
      int n;
      n = 0;
      while (atten_o !== exp && n < tmo) begin
         @(posedge clk_i);
         n++;
      end
      checks++;
      if (atten_o !== exp) begin
         fail_count++;
         $display("unexpected atten at %0t: got %h expected %h", $time, atten_o, exp);
      end
   endtask

   // Compares a bus word.
   task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One classic Wishbone cycle; the request holds until ack is sampled high.
   task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] wd,
                           output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_wdat <= wd;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         test_done();
      end
      rd = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask

   // Sets the pins, resets for 16 cycles and polls the running flag.
   task automatic power_up(input logic s, input logic st, input logic hi, input logic lo,
                           input logic [5:0] pw, output logic [31:0] rd);
      int n;
      host_u.set_pins(s, st, hi, lo, pw);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      n = 0;
      rd = 32'h0000_0000;
      while (rd[`SAC_STAT_RUN_BIT] !== 1'b1 && n < 20) begin
         wb_cycle(1'b0, `SAC_ADR_STATUS, 32'h0000_0000, rd);
         n++;
      end
   endtask

   // Main sequence.
   initial begin
      seed = 32'hC59FE9D3;
      {rst_i, wb_cyc, wb_stb, wb_we} = 4'h8;
      {wb_adr, wb_sel, wb_wdat} = 44'h000_0000_0000;
      {fail_count, checks, cycles} = '0;
      // Parallel power-up with the strobe low, all four select combinations.
      for (int k = 0; k < 4; k++) begin
         w = 6'($random(seed));
         power_up(1'b0, 1'b0, k[1], k[0], w, d);
         check_atten(pup_exp(k), 0);
         check_word(32'h0000_0024, d & 32'h0000_0035);
      end
      host_u.set_weights(~w);
      repeat (12) @(posedge clk_i);
      check_atten(6'h3E, 0);
      host_u.strobe_pulse();
      check_atten(~w, 20);
      host_u.set_weights(w);
      host_u.send_word(~w);
      check_atten(~w, 0);
      host_u.strobe_pulse();
      check_atten(w, 20);
      wb_cycle(1'b1, `SAC_ADR_CTRL, 32'h0000_0001, d);
      check_atten(6'h3E, 20);
      // Parallel power-up with the strobe high, then direct mode.
      power_up(1'b0, 1'b1, 1'b1, 1'b1, w, d);
      check_atten(w, 0);
      check_word(32'h0000_0036, d & 32'h0000_0037);
      for (int i = 0; i < 7; i++) begin
         v = (i == 6) ? 6'h3F : 6'h01 << i;
         host_u.set_weights(v);
         check_atten(v, 20);
      end
      repeat (8) begin
         w = 6'($random(seed));
         host_u.set_weights(w);
         check_atten(w, 20);
      end
      // Serial power-up, then latched serial words.
      w = 6'($random(seed));
      power_up(1'b1, 1'b0, 1'b0, 1'b1, w, d);
      check_atten(w, 0);
      check_word(32'h0000_0015, d & 32'h0000_0037);
      prev = w;
      repeat (8) begin
         v = 6'($random(seed));
         host_u.set_weights(~v);
         host_u.send_word(v);
         check_atten(prev, 0);
         wb_cycle(1'b0, `SAC_ADR_SHIFT, 32'h0000_0000, d);
         check_word({26'h000_0000, v}, d);
         host_u.strobe_pulse();
         check_atten(v, 20);
         prev = v;
      end
      // Shifting with the strobe held high passes straight through.
      v = ~prev;
      host_u.set_pins(1'b1, 1'b1, 1'b0, 1'b1, prev);
      host_u.send_word(v);
      check_atten(v, 20);
      host_u.set_pins(1'b1, 1'b0, 1'b0, 1'b1, prev);
      // Unmapped and read-only places.
      wb_cycle(1'b0, 8'h10, 32'h0000_0000, d);
      check_word(32'h0000_0000, d);
      wb_cycle(1'b1, `SAC_ADR_ATTEN, 32'hFFFF_FFFF, d);
      wb_cycle(1'b0, `SAC_ADR_ATTEN, 32'h0000_0000, d);
      check_word({26'h000_0000, v}, d);
      test_done();
   end
endmodule
